// *** verilog/lfc_map.vh ***
// Constants for the line frame checksum and acknowledge block.
// Assumes inclusion by the design files; definitions only.
`ifndef LFC_MAP_VH
`define LFC_MAP_VH
// ----------------------------------------
// Seed layout
// ----------------------------------------
`define LFC_SEED_RW_BIT 7
`define LFC_SEED_IDX_LSB 3
`define LFC_RW_WRITE 1'b0
`define LFC_RW_READ 1'b1
// ----------------------------------------
// Checksum constants
// ----------------------------------------
`define LFC_SUM_MAX 9'h0ff
`define LFC_INV_MASK 8'hff
`define LFC_ACK_OK 1'b1
`define LFC_ACK_BAD 1'b0
// Count value of the eighth received checksum bit
`define LFC_CHK_LAST 4'h7
`define LFC_CNT_W 8
`endif

// *** verilog/lfc_acc.v ***
// End-around-carry checksum accumulator for one transfer.
// Assumes seed, bit and finish strobes arrive one per cycle at most.
`timescale 1ns/1ps
`include "lfc_map.vh"
module lfc_acc (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Control
   input wire seed_en,
   input wire [7:0] seed_val,
   input wire bit_en,
   input wire bit_val,
   input wire flush_en,
   // Result
   output reg [7:0] chk_r
);
   reg [7:0] acc_r;
   reg [7:0] byte_r;
   reg [2:0] pos_r;
   reg [7:0] acc_nxt;
   reg [7:0] byte_nxt;

   // ----------------------------------------
   // Byte add with end-around carry
   // ----------------------------------------
   function [7:0] eac_add;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         if (s > `LFC_SUM_MAX) begin
            s = s - `LFC_SUM_MAX; // [RL4]
         end
         eac_add = s[7:0];
      end
   endfunction

   // Next byte and accumulator
   always @* begin
      byte_nxt = byte_r;
      acc_nxt = acc_r;
      if (bit_en) begin
         byte_nxt[pos_r] = bit_val; // LSB first [RL3]
         if (pos_r == 3'h7) begin
            acc_nxt = eac_add(acc_r, byte_nxt);
         end
      end
   end

   // Accumulate; partial byte is already zero padded on flush
   always @(posedge clk) begin
      if (rst || seed_en) begin
         acc_r <= rst ? 8'h00 : seed_val; // [RL2]
         byte_r <= 8'h00;
         pos_r <= 3'h0;
         chk_r <= 8'h00;
      end else if (flush_en) begin
         if (pos_r != 3'h0) begin
            chk_r <= eac_add(acc_r, byte_r) ^ `LFC_INV_MASK; // [RL3] [RL5]
         end else begin
            chk_r <= acc_r ^ `LFC_INV_MASK; // [RL5]
         end
      end else if (bit_en) begin
         if (pos_r == 3'h7) begin
            byte_r <= 8'h00;
         end else begin
            byte_r <= byte_nxt;
         end
         acc_r <= acc_nxt; // [RL4]
         pos_r <= pos_r + 3'h1;
      end
   end
endmodule

// *** verilog/lfc_top.v ***
// Checksum generation and checking for index data transfers on the line.
// Assumes a bit decoder upstream delivering decoded bits as strobes.
// Summary of operation
// RL1: Every index transfer carries an 8-bit checksum over flag, index and payload.
// RL2: The accumulator starts as flag in bit 7, index in bits 6..3, zeros below.
// RL3: Payload is grouped into bytes LSB first; a short last byte is zero padded.
// RL4: Each byte is added, and 255 is subtracted whenever the sum passes 255.
// RL5: The checksum sent or compared is the accumulator xor all ones.
// RL6: The sender sends the inverted checksum, the receiver recomputes and compares.
// RL7: The device drives its acknowledge bit right after the last checksum bit.
// RL8: The acknowledge bit goes out after writes only, never after reads.
// RL9: The flag is 0 for a write and 1 for a read, as placed in the seed.
// RL10: The acknowledge reports the write checksum match; a mismatch blocks the write.
// RL11: The master discards read data whose checksum does not match.
`timescale 1ns/1ps
`include "lfc_map.vh"
module lfc_top (
   // Clock and reset
   input wire CLK_SYS,
   input wire RESET,
   // Frame header from the line decoder
   input wire FRAME_START,
   input wire READ_NOT_WRITE_FLAG,
   input wire [3:0] INDEX,
   // Payload bit strobes
   input wire PAY_BIT_VALID,
   input wire PAY_BIT,
   input wire PAY_DONE,
   // Received checksum bits, MSB first
   input wire CHK_BIT_VALID,
   input wire CHK_BIT,
   // Transmit checksum request for read answers
   input wire TX_CHK_REQ,
   // Results
   output reg [7:0] TX_CHECKSUM,
   output reg TX_CHECKSUM_VALID,
   output reg CHECK_DONE,
   output reg CHECK_OK,
   output reg WRITE_COMMIT,
   output reg ACK_REQ,
   output reg ACK_VALUE
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   localparam ST_IDLE = 2'h0;
   localparam ST_PAY = 2'h1;
   localparam ST_CHK = 2'h2;
   localparam ST_CMP = 2'h3;

   reg [1:0] state_r;
   reg [1:0] state_nxt;
   reg rw_r;
   reg [7:0] rx_chk_r;
   reg [3:0] chk_cnt_r;
   reg flush_r;
   wire [7:0] calc_chk;
   wire [7:0] seed;
   wire pay_bit_take;
   wire pay_end_take;
   wire chk_bit_take;
   wire chk_last_take;
   wire tx_req_take;
   wire cmp_fire;
   wire chk_match;
   wire wr_frame;

   // ----------------------------------------
   // Phase qualifiers
   // ----------------------------------------
   // True while the frame sequencer sits in the given phase
   function in_phase;
      input [1:0] cur;
      input [1:0] want;
      begin
         in_phase = (cur == want);
      end
   endfunction

   // Strobes outside their phase are dropped here, so a stray bit
   // from a noisy line cannot corrupt the running sum
   assign pay_bit_take = PAY_BIT_VALID && in_phase(state_r, ST_PAY);
   assign pay_end_take = PAY_DONE && in_phase(state_r, ST_PAY);
   assign chk_bit_take = CHK_BIT_VALID && in_phase(state_r, ST_CHK);
   assign chk_last_take = chk_bit_take && (chk_cnt_r == `LFC_CHK_LAST);
   assign tx_req_take = TX_CHK_REQ && in_phase(state_r, ST_CHK) && (rw_r == `LFC_RW_READ);
   // A new frame start wins over a compare still pending
   assign cmp_fire = in_phase(state_r, ST_CMP) && !FRAME_START;
   // Received sum against the inverted local sum [RL6]
   assign chk_match = (rx_chk_r == TX_CHECKSUM);
   // Direction of the frame in flight [RL9]
   assign wr_frame = (rw_r == `LFC_RW_WRITE);
   // Limitation: a frame cut before its checksum waits in ST_PAY or ST_CHK until the
   // next frame start; the line decoder upstream owns any timeout

   // ----------------------------------------
   // Accumulator
   // ----------------------------------------
   // Seed built from flag and index [RL2] [RL9]
   assign seed = {READ_NOT_WRITE_FLAG, INDEX, 3'h0};

   // Seeded on every frame start, so an aborted frame leaves no residue
   lfc_acc lfc_acc_i (
      .clk(CLK_SYS),
      .rst(RESET),
      .seed_en(FRAME_START),
      .seed_val(seed),
      .bit_en(pay_bit_take),
      .bit_val(PAY_BIT),
      .flush_en(pay_end_take),
      .chk_r(calc_chk)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always @* begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (FRAME_START) begin
               state_nxt = ST_PAY;
            end
         end
         ST_PAY: begin
            if (PAY_DONE) begin
               state_nxt = ST_CHK;
            end
         end
         ST_CHK: begin
            if (chk_last_take) begin // Eighth checksum bit
               state_nxt = ST_CMP;
            end
         end
         ST_CMP: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
      if (FRAME_START) begin
         state_nxt = ST_PAY; // New frame aborts any stale one
      end
   end

   // ----------------------------------------
   // Frame sequencing
   // ----------------------------------------
   // Phase register and frame direction latch
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         state_r <= ST_IDLE;
         rw_r <= `LFC_RW_WRITE;
      end else begin
         state_r <= state_nxt;
         if (FRAME_START) begin
            rw_r <= READ_NOT_WRITE_FLAG; // [RL9]
         end
      end
   end

   // ----------------------------------------
   // Transmit checksum
   // ----------------------------------------
   // Flush strobe delayed one cycle to let the accumulator settle
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         flush_r <= 1'b0;
      end else begin
         flush_r <= pay_end_take;
      end
   end

   // Inverted checksum ready two cycles after payload end [RL1] [RL6]
   // Held until the next payload end, so a late request still sees it
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         TX_CHECKSUM <= 8'h00;
         TX_CHECKSUM_VALID <= 1'b0;
      end else begin
         if (flush_r) begin
            TX_CHECKSUM <= calc_chk;
         end
         // Read answers send the computed checksum on request [RL6]
         TX_CHECKSUM_VALID <= tx_req_take;
      end
   end

   // ----------------------------------------
   // Checksum receive
   // ----------------------------------------
   // Received checksum shifts in MSB first; the count restarts per frame
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         rx_chk_r <= 8'h00;
         chk_cnt_r <= 4'h0;
      end else if (FRAME_START) begin
         chk_cnt_r <= 4'h0;
      end else if (chk_bit_take) begin
         rx_chk_r <= {rx_chk_r[6:0], CHK_BIT};
         chk_cnt_r <= chk_cnt_r + 4'h1;
      end
   end

   // ----------------------------------------
   // Compare and acknowledge
   // ----------------------------------------
   // Compare right after the last checksum bit [RL6]
   // Pulses clear each cycle; CHECK_OK holds until the next compare, ACK_VALUE until the next write compare
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         CHECK_DONE <= 1'b0;
         CHECK_OK <= 1'b0;
         WRITE_COMMIT <= 1'b0;
         ACK_REQ <= 1'b0;
         ACK_VALUE <= `LFC_ACK_BAD;
      end else begin
         CHECK_DONE <= cmp_fire;
         ACK_REQ <= cmp_fire && wr_frame; // Writes only [RL7] [RL8]
         // A failed write never reaches configuration memory [RL10]
         WRITE_COMMIT <= cmp_fire && wr_frame && chk_match;
         if (cmp_fire) begin
            CHECK_OK <= chk_match;
            if (wr_frame) begin
               ACK_VALUE <= chk_match ? `LFC_ACK_OK : `LFC_ACK_BAD; // [RL10]
            end
         end
      end
   end
endmodule

// *** tb/lfc_top_props.sv ***
// Properties on the ports of the frame checksum block.
// Assumes binding to lfc_top; one clock, sync reset.
`timescale 1ns/1ps
module lfc_props (
   // Clock and reset
   input wire CLK_SYS,
   input wire RESET,
   // Frame inputs
   input wire FRAME_START,
   input wire READ_NOT_WRITE_FLAG,
   input wire [3:0] INDEX,
   input wire PAY_DONE,
   input wire CHK_BIT_VALID,
   // Results
   input wire [7:0] TX_CHECKSUM,
   input wire TX_CHECKSUM_VALID,
   input wire CHECK_DONE,
   input wire CHECK_OK,
   input wire WRITE_COMMIT,
   input wire ACK_REQ,
   input wire ACK_VALUE
);
   // ----
   // Rules
   // ----
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   reg rd_r;
   // Direction of the frame in flight
   always @(posedge CLK_SYS)
      if (RESET) rd_r <= 1'b0;
      else if (FRAME_START) rd_r <= READ_NOT_WRITE_FLAG;
   sequence s_empty;
      FRAME_START ##1 PAY_DONE;
   endsequence
   sequence s_chk8;
      CHK_BIT_VALID [*8] ##1 !CHK_BIT_VALID;
   endsequence
   a_seed_empty: assert property (s_empty |-> ##3
      TX_CHECKSUM == ~{$past(READ_NOT_WRITE_FLAG, 4), $past(INDEX, 4), 3'h0})
      else $error("empty frame sum");
   a_done_time: assert property (s_chk8 |-> ##[1:2] CHECK_DONE)
      else $error("check late");
   a_done_pulse: assert property (CHECK_DONE |=> !CHECK_DONE)
      else $error("done held");
   a_ack_write: assert property (CHECK_DONE |-> ACK_REQ == !rd_r)
      else $error("ack kind");
   a_ack_done: assert property (ACK_REQ |-> CHECK_DONE)
      else $error("ack alone");
   a_ack_value: assert property (ACK_REQ |-> ACK_VALUE == CHECK_OK)
      else $error("ack value");
   a_commit_ok: assert property (WRITE_COMMIT |-> ACK_REQ && CHECK_OK)
      else $error("bad commit");
   a_ok_hold: assert property (!CHECK_DONE |-> $stable(CHECK_OK))
      else $error("ok moved");
   a_txv_read: assert property (TX_CHECKSUM_VALID |-> rd_r)
      else $error("tx sum in write");
endmodule
bind lfc_top lfc_props lfc_props_i (.CLK_SYS, .RESET, .FRAME_START, .READ_NOT_WRITE_FLAG,
   .INDEX, .PAY_DONE, .CHK_BIT_VALID, .TX_CHECKSUM, .TX_CHECKSUM_VALID, .CHECK_DONE,
   .CHECK_OK, .WRITE_COMMIT,
   .ACK_REQ, .ACK_VALUE);

// *** tb/lfc_ecu.sv ***
// Master model sending decoded frames to the block.
// Assumes the block's clock; drives 1 ns after rising edges.
`timescale 1ns/1ps
module lfc_ecu (
   // Clock
   input wire CLK_SYS,
   // Strobes to the block
   output logic FRAME_START,
   output logic READ_NOT_WRITE_FLAG,
   output logic [3:0] INDEX,
   output logic PAY_BIT_VALID,
   output logic PAY_BIT,
   output logic PAY_DONE,
   output logic CHK_BIT_VALID,
   output logic CHK_BIT,
   output logic TX_CHK_REQ,
   // Results
   input wire [7:0] TX_CHECKSUM,
   input wire TX_CHECKSUM_VALID,
   input wire CHECK_DONE,
   input wire CHECK_OK,
   input wire WRITE_COMMIT,
   input wire ACK_REQ,
   input wire ACK_VALUE
);
   // ----
   // Frame driver
   // ----
   logic [7:0] got_tx, got;
   logic got_txv, got_keep;
   initial {FRAME_START, READ_NOT_WRITE_FLAG, INDEX, PAY_BIT_VALID, PAY_BIT, PAY_DONE,
      CHK_BIT_VALID, CHK_BIT, TX_CHK_REQ} = '0;
   // One frame; bad flips the sum LSB to force a mismatch
   task automatic frame(input logic r, input logic [3:0] x, input int n,
         input logic [15:0] d, input logic bad);
      logic [8:0] s;
      logic [15:0] m;
      logic [7:0] c;
      logic [7:0] e;
      m = d & 16'((17'h1 << n) - 17'h1);
      s = {1'b0, r, x, 3'h0};
      s = s + {1'b0, m[7:0]};
      if (s > 9'd255) s = s - 9'd255;
      s = s + {1'b0, m[15:8]};
      if (s > 9'd255) s = s - 9'd255;
      e = ~s[7:0];
      c = e ^ {7'h0, bad};
      @(posedge CLK_SYS) #1;
      {FRAME_START, READ_NOT_WRITE_FLAG, INDEX} = {1'b1, r, x};
      @(posedge CLK_SYS) #1;
      FRAME_START = 1'b0;
      for (int k = 0; k < n; k++) begin
         {PAY_BIT_VALID, PAY_BIT} = {1'b1, d[k]};
         @(posedge CLK_SYS) #1;
      end
      {PAY_BIT_VALID, PAY_DONE} = 2'b01;
      @(posedge CLK_SYS) #1;
      PAY_DONE = 1'b0;
      repeat (2) @(posedge CLK_SYS) #1;
      // Asked in writes too: the block must refuse there
      TX_CHK_REQ = 1'b1;
      @(posedge CLK_SYS) #1;
      TX_CHK_REQ = 1'b0;
      got_tx = TX_CHECKSUM;
      got_txv = TX_CHECKSUM_VALID;
      // Master keeps read data only if its own sum agrees
      got_keep = r && (got_tx === e);
      for (int k = 7; k >= 0; k--) begin
         {CHK_BIT_VALID, CHK_BIT} = {1'b1, c[k]};
         @(posedge CLK_SYS) #1;
      end
      CHK_BIT_VALID = 1'b0;
      got = 8'h0;
      repeat (4) begin
         @(posedge CLK_SYS) #1;
         if (CHECK_DONE === 1'b1) got = {4'h1, CHECK_OK, ACK_REQ, ACK_VALUE, WRITE_COMMIT};
      end
   endtask
endmodule

// *** tb/lfc_top_test.sv ***
// Self-checking bench for the frame checksum block.
// Assumes the master model and the bound checker.
`timescale 1ns/1ps
module lfc_top_test;
   // ----
   // Bench
   // ----
   logic CLK_SYS, RESET, FRAME_START, READ_NOT_WRITE_FLAG, PAY_BIT_VALID, PAY_BIT, PAY_DONE;
   logic CHK_BIT_VALID, CHK_BIT, TX_CHK_REQ, TX_CHECKSUM_VALID, CHECK_DONE, CHECK_OK;
   logic WRITE_COMMIT, ACK_REQ, ACK_VALUE;
   logic [3:0] INDEX;
   logic [7:0] TX_CHECKSUM;
   int fails = 0, n_compared = 0;
   lfc_top lfc_top_i (.CLK_SYS, .RESET, .FRAME_START, .READ_NOT_WRITE_FLAG, .INDEX,
      .PAY_BIT_VALID, .PAY_BIT, .PAY_DONE, .CHK_BIT_VALID, .CHK_BIT, .TX_CHK_REQ,
      .TX_CHECKSUM, .TX_CHECKSUM_VALID, .CHECK_DONE, .CHECK_OK, .WRITE_COMMIT,
      .ACK_REQ, .ACK_VALUE);
   lfc_ecu lfc_ecu_i (.CLK_SYS, .FRAME_START, .READ_NOT_WRITE_FLAG, .INDEX, .PAY_BIT_VALID,
      .PAY_BIT, .PAY_DONE, .CHK_BIT_VALID, .CHK_BIT, .TX_CHK_REQ, .TX_CHECKSUM,
      .TX_CHECKSUM_VALID, .CHECK_DONE, .CHECK_OK, .WRITE_COMMIT, .ACK_REQ, .ACK_VALUE);
   task check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
      end
   endtask
   // Results packed as done, ok, ack, ack value, commit
   task t_read;
      lfc_ecu_i.frame(1'b1, 4'h2, 11, 16'h03ea, 1'b0);
      check(lfc_ecu_i.got_tx, 8'h81);
      check(lfc_ecu_i.got, 8'h18);
      check({7'h0, lfc_ecu_i.got_txv}, 8'h01);
      check({7'h0, lfc_ecu_i.got_keep}, 8'h01);
      $display("read test done");
   endtask
   task t_carry;
      lfc_ecu_i.frame(1'b0, 4'hf, 16, 16'hffff, 1'b0);
      check(lfc_ecu_i.got, 8'h1f);
      check(lfc_ecu_i.got_tx, 8'h87);
      check({7'h0, lfc_ecu_i.got_txv}, 8'h00);
      $display("carry test done");
   endtask
   task t_bad;
      lfc_ecu_i.frame(1'b0, 4'h9, 8, 16'h005a, 1'b1);
      check(lfc_ecu_i.got_tx, 8'h5d);
      check(lfc_ecu_i.got, 8'h14);
      check({7'h0, lfc_ecu_i.got_txv}, 8'h00);
      $display("bad test done");
   endtask
   task t_empty;
      lfc_ecu_i.frame(1'b0, 4'h5, 0, 16'h0000, 1'b0);
      check(lfc_ecu_i.got_tx, 8'hd7);
      check(lfc_ecu_i.got, 8'h1f);
      check({7'h0, lfc_ecu_i.got_txv}, 8'h00);
      $display("empty test done");
   endtask
   task print_verdict;
      $display("compared %0d, mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // Clock, then reset and the tests
   initial begin
      CLK_SYS = 1'b0;
      forever #2 CLK_SYS = ~CLK_SYS;
   end
   initial begin
      RESET = 1'b1;
      repeat (3) @(posedge CLK_SYS);
      #1 RESET = 1'b0;
      t_read;
      t_carry;
      t_bad;
      t_empty;
      print_verdict;
   end
   // Four frames need well under 1 us
   initial begin
      #5000;
      fails++;
      print_verdict;
   end
endmodule
